// file: tb/hsw_core_model.sv
// Purpose: cpu core and request source model facing the halt wake block
// Assumes: one clock; request flags are levels held until serviced
// Notes:   a vectored take clears the serviced flag, as a real acknowledge does
`timescale 1ns/1ps
`default_nettype none

module hsw_core_model
	import hsw_pkg::*;
(
	input  wire logic            clk_in,
	input  wire logic            rst_n_in,
	input  wire logic            halt_go_in,
	input  wire logic [NSRC-1:0] set_irq_in,
	input  wire logic            clr_all_in,
	input  wire logic            cpu_en_in,
	input  wire logic            vec_take_in,
	input  wire logic [SRCW-1:0] vec_src_in,
	output logic                 halt_exec_out,
	output logic [NSRC-1:0]      irq_out
);
	// a gated core cannot fetch, so it only strobes halt while clocked
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			halt_exec_out <= 1'b0;
			irq_out       <= '0;
		end else begin
			halt_exec_out <= halt_go_in & cpu_en_in;
			irq_out       <= clr_all_in ? '0 : (irq_out | set_irq_in) & ~(vec_take_in ? 8'h1 << vec_src_in : 8'h0);
		end
	end
endmodule // hsw_core_model

`default_nettype wire

// file: tb/test_halt_standby_wake_control.sv
// Purpose: self-checking bench of the halt wake block
// Assumes: 200 MHz clock; bus answers with one wait cycle
// Notes:   completion pulses are matched against a queue of expectations
`timescale 1ns/1ps
`default_nettype none

module test_halt_standby_wake_control
	import hsw_pkg::*;
;
	logic            clk, rst_n, go, clr, osc, acc, srk, opt, hx, v, pv;
	logic [SRCW-1:0] ps;
	logic            cen, hlt, rsm, vtk, boot, wdt, mosc;
	logic [NSRC-1:0] set, irq;
	logic [SRCW-1:0] vsrc, s;
	logic [31:0]     lf, rd;
	logic [2:0]      rows [6] = '{3'b000, 3'b010, 3'b101, 3'b110, 3'b111, 3'b111};
	hsw_avs_req_t    req;
	hsw_avs_rsp_t    rsp;
	int              error_cnt, compares, cyc, t;
	typedef struct {logic v; logic [SRCW-1:0] s; int t;} hsw_exp_t;
	hsw_exp_t        q[$];
	hsw_exp_t        e;

	hsw_halt_wake uut (.CLK_SYS_IN(clk), .RST_N_IN(rst_n), .AVS_REQ_IN(req), .AVS_RSP_OUT(rsp),
		.HALT_EXEC_IN(hx), .CLK_SRC_OSC_IN(osc), .IRQ_REQ_IN(irq), .GLOBAL_IRQ_ACCEPT_IN(acc),
		.CURRENT_SERVICE_RANK_IN(srk), .OPT_LSO_STOP_IN(opt), .CPU_CLK_EN_OUT(cen), .HALTED_OUT(hlt),
		.RESUME_NEXT_OUT(rsm), .VECTOR_TAKE_OUT(vtk), .VECTOR_SRC_OUT(vsrc), .BOOT_VECTOR_OUT(boot),
		.WDT_CLK_EN_OUT(wdt), .MAIN_OSC_EN_OUT(mosc));
	hsw_core_model core (.clk_in(clk), .rst_n_in(rst_n), .halt_go_in(go), .set_irq_in(set),
		.clr_all_in(clr), .cpu_en_in(cen), .vec_take_in(vtk), .vec_src_in(vsrc), .halt_exec_out(hx),
		.irq_out(irq));

	// ----------------------
	// helpers
	// ----------------------
	task automatic chk(input string n, input logic [31:0] sn, input logic [31:0] ex);
		compares++;
		if (sn !== ex) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", n, ex, sn);
		end
	endtask

	task automatic finish_test();
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// request stands until waitrequest is seen low at a rising edge; read data taken there
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] o);
		@(posedge clk);
		req.read <= !w;
		req.write <= w;
		req.address <= a;
		req.byteenable <= 4'hf;
		req.writedata <= d;
		do @(posedge clk); while (rsp.waitrequest !== 1'b0);
		o = rsp.readdata;
		req.read <= 1'b0;
		req.write <= 1'b0;
	endtask

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// cycle count doubles as the hang limit
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			error_cnt++;
			finish_test();
		end
	end

	// each completion pulse takes the oldest expectation off the queue
	always @(negedge clk) if (rst_n && (rsm | vtk)) begin
		if (q.size() == 0) begin
			chk("spurious", 1, 0);
		end else begin
			e = q.pop_front();
			chk("kind", vtk, e.v);
			chk("wait", cyc, e.t);
			chk("src", vsrc, e.s);
			chk("cpu_en", cen, 1);
		end
	end

	// ----------------------
	// main sequence
	// ----------------------
	initial begin
		rst_n = 0; go = 0; clr = 0; set = '0; osc = 0; acc = 0; srk = 0; opt = 0;
		req = '0; error_cnt = 0; compares = 0; cyc = 0; lf = 32'h8b0adf4a; pv = 0; ps = '0;
		repeat (10) @(posedge clk);
		rst_n <= 1;
		@(posedge clk);
		@(negedge clk) chk("boot", boot, 1);
		bus(0, HSW_OFS_MASK, 0, rd);
		chk("mask_rst", rd, 32'(HSW_MASK_RST));
		bus(0, HSW_OFS_RANK, 0, rd);
		chk("rank_rst", rd, 32'(HSW_RANK_RST));
		bus(0, 4'h2, 0, rd);
		chk("unmapped", rd, 0);
		bus(1, HSW_OFS_MASK, 0, rd);
		// a pending request without the halt instruction leaves the core running
		set <= 8'h10;
		@(posedge clk) set <= 0;
		repeat (6) @(posedge clk);
		@(negedge clk) chk("no_halt", hlt, 0);
		@(posedge clk) clr <= 1;
		@(posedge clk) clr <= 0;
		// rows walk five of the eight flag mixes; the last row masks its source
		for (int r = 0; r < 6; r++) begin
			lf = lfsr(lf);
			s = lf[2:0];
			v = rows[r][1] & (!rows[r][2] | rows[r][0]);
			bus(1, HSW_OFS_MASK, (r == 5) ? 32'hff : {24'h0, ~(8'h1 << s)}, rd);
			bus(1, HSW_OFS_RANK, {24'h0, {8{rows[r][2]}}}, rd);
			acc <= rows[r][1];
			srk <= rows[r][0];
			osc <= lf[3];
			opt <= lf[4];
			go <= 1;
			@(posedge clk) go <= 0;
			repeat (3) @(posedge clk);
			bus(0, HSW_OFS_STATUS, 0, rd);
			chk("halted", rd[0], 1);
			chk("clk_src", rd[3], osc);
			chk("last_vec", rd[2], pv);
			chk("last_src", rd[6:4], ps);
			@(negedge clk) chk("gates", {cen, mosc, wdt}, {2'b01, !opt});
			@(posedge clk) set <= 8'h1 << s;
			@(negedge clk) t = cyc;
			if (r < 5) begin
				q.push_back('{v, s, t + 1 + (v ? HSW_WAIT_VEC_CLK : HSW_WAIT_NEXT_CLK)});
				pv = v;
				ps = s;
			end
			@(posedge clk) set <= 0;
			repeat (12) @(posedge clk);
			clr <= 1;
			@(posedge clk) clr <= 0;
		end
		@(negedge clk) chk("held", hlt, 1);
		bus(0, HSW_OFS_COUNT, 0, rd);
		chk("entries", rd, 6);
		@(posedge clk) rst_n <= 0;
		@(negedge clk) chk("rst_exit", hlt, 0);
		@(posedge clk) rst_n <= 1;
		@(posedge clk);
		@(negedge clk) chk("boot2", boot, 1);
		finish_test();
	end
endmodule // test_halt_standby_wake_control

`default_nettype wire

// file: verilog/hsw_halt_wake.sv
// Purpose: halt state entry, hold and wake-up sequencing for a small cpu core
// Assumes: all inputs synchronous to CLK_SYS_IN; request flags are levels
// Notes:   one avalon-mm slave holds mask, rank, status and entry count
//
// Our own choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module hsw_halt_wake
	import hsw_pkg::*;
(
	input  wire logic            CLK_SYS_IN,
	input  wire logic            RST_N_IN,
	input  wire hsw_avs_req_t    AVS_REQ_IN,
	output var  hsw_avs_rsp_t    AVS_RSP_OUT,
	input  wire logic            HALT_EXEC_IN,
	input  wire logic            CLK_SRC_OSC_IN,
	input  wire logic [NSRC-1:0] IRQ_REQ_IN,
	input  wire logic            GLOBAL_IRQ_ACCEPT_IN,
	input  wire logic            CURRENT_SERVICE_RANK_IN,
	input  wire logic            OPT_LSO_STOP_IN,
	output logic                 CPU_CLK_EN_OUT,
	output logic                 HALTED_OUT,
	output logic                 RESUME_NEXT_OUT,
	output logic                 VECTOR_TAKE_OUT,
	output logic [SRCW-1:0]      VECTOR_SRC_OUT,
	output logic                 BOOT_VECTOR_OUT,
	output logic                 WDT_CLK_EN_OUT,
	output logic                 MAIN_OSC_EN_OUT
);

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	hsw_reg_t        q;
	hsw_reg_t        d;
	logic [NSRC-1:0] pend;
	logic            wake_any;
	logic [SRCW-1:0] wake_src;
	logic            vec_ok;
	logic            acc;

	// unmasked requests only; masked ones are invisible here
	assign pend     = IRQ_REQ_IN & ~q.mask;
	assign wake_any = |pend;

	// lowest index wins among unmasked pending sources
	always_comb begin
		wake_src = '0;
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (pend[i]) begin
				wake_src = SRCW'(i);
			end
		end
	end

	// high rank needs global accept only; low rank also needs service rank 1
	assign vec_ok = GLOBAL_IRQ_ACCEPT_IN && (!q.rank[wake_src] || CURRENT_SERVICE_RANK_IN);

	// bus access completes on the cycle waitrequest is low
	assign acc = (AVS_REQ_IN.read || AVS_REQ_IN.write) && !q.rsp.waitrequest;

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		d          = q;
		d.resume_p = 1'b0;
		d.vector_p = 1'b0;
		d.boot_p   = 1'b0;
		// first cycle after reset release starts the core at the reset vector
		if (!q.boot_done) begin
			d.boot_p    = 1'b1;
			d.boot_done = 1'b1;
		end
		case (q.st)
			HSW_RUN: begin
				// only the instruction strobe enters halt; clock source is just recorded
				if (HALT_EXEC_IN) begin
					d.st       = HSW_HALT;
					d.cpu_en   = 1'b0;
					d.clk_src  = CLK_SRC_OSC_IN;
					d.halt_cnt = q.halt_cnt + 8'h01;
				end
			end
			HSW_HALT: begin
				// decision is frozen at release so late flag changes do not matter
				if (wake_any) begin
					d.st       = HSW_WAKE;
					d.src      = wake_src;
					d.vec_pend = vec_ok;
					d.cnt      = vec_ok ? HSW_CNT_VEC : HSW_CNT_NEXT;
				end
			end
			HSW_WAKE: begin
				if (q.cnt == 4'h0) begin
					d.st       = HSW_RUN;
					d.cpu_en   = 1'b1;
					d.last_vec = q.vec_pend;
					d.vector_p = q.vec_pend;
					d.resume_p = !q.vec_pend;
					d.vec_src  = q.src;
				end else begin
					d.cnt = q.cnt - 4'h1;
				end
			end
			default: begin
				d.st     = HSW_RUN;
				d.cpu_en = 1'b1;
			end
		endcase
		// watchdog clock withheld only while stopped and the option allows it
		d.wdt_en = (d.st == HSW_RUN) || !OPT_LSO_STOP_IN;
		d.osc_en = 1'b1;
		// halted pin gets its own flop rather than a decode of the state
		d.halted = (d.st != HSW_RUN);
		// avalon slave: one wait cycle, then a single-cycle answer
		d.rsp.waitrequest = 1'b1;
		if ((AVS_REQ_IN.read || AVS_REQ_IN.write) && q.rsp.waitrequest) begin
			d.rsp.waitrequest = 1'b0;
			d.rsp.readdata    = 32'h0000_0000;
			if (AVS_REQ_IN.read) begin
				case (AVS_REQ_IN.address)
					HSW_OFS_MASK:   d.rsp.readdata[NSRC-1:0] = q.mask;
					HSW_OFS_RANK:   d.rsp.readdata[NSRC-1:0] = q.rank;
					HSW_OFS_STATUS: begin
						d.rsp.readdata[HSW_ST_HALTED] = (q.st == HSW_HALT);
						d.rsp.readdata[HSW_ST_WAKING] = (q.st == HSW_WAKE);
						d.rsp.readdata[HSW_ST_LASTV]  = q.last_vec;
						d.rsp.readdata[HSW_ST_CLKSRC] = q.clk_src;
						d.rsp.readdata[HSW_ST_SRC_LO +: SRCW] = q.vec_src;
					end
					HSW_OFS_COUNT:  d.rsp.readdata[7:0] = q.halt_cnt;
					default:        d.rsp.readdata = 32'h0000_0000;
				endcase
			end
		end
		// writes land at the completing edge; unmapped offsets are ignored
		if (acc && AVS_REQ_IN.write && AVS_REQ_IN.byteenable[0]) begin
			case (AVS_REQ_IN.address)
				HSW_OFS_MASK: d.mask = AVS_REQ_IN.writedata[NSRC-1:0];
				HSW_OFS_RANK: d.rank = AVS_REQ_IN.writedata[NSRC-1:0];
				default:      d.mask = q.mask;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	// async reset also drops any halt in progress
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			q <= HSW_REG_RST;
		end else begin
			q <= d;
		end
	end

	// outputs straight from flops
	assign AVS_RSP_OUT     = q.rsp;
	assign CPU_CLK_EN_OUT  = q.cpu_en;
	assign HALTED_OUT      = q.halted;
	assign RESUME_NEXT_OUT = q.resume_p;
	assign VECTOR_TAKE_OUT = q.vector_p;
	assign VECTOR_SRC_OUT  = q.vec_src;
	assign BOOT_VECTOR_OUT = q.boot_p;
	assign WDT_CLK_EN_OUT  = q.wdt_en;
	assign MAIN_OSC_EN_OUT = q.osc_en;

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge CLK_SYS_IN); endclocking
	default disable iff (!RST_N_IN);

	property p_entry_only_on_strobe;
		$rose(q.st == HSW_HALT) |-> $past(HALT_EXEC_IN) && $past(q.st) == HSW_RUN;
	endproperty
	a_entry_only_on_strobe: assert property (p_entry_only_on_strobe) else $error("halt entered without strobe");

	property p_entry_any_clock;
		q.st == HSW_RUN && HALT_EXEC_IN |=> q.st == HSW_HALT && q.clk_src == $past(CLK_SRC_OSC_IN);
	endproperty
	a_entry_any_clock: assert property (p_entry_any_clock) else $error("halt strobe not taken");

	property p_cpu_frozen;
		q.st != HSW_RUN |-> !CPU_CLK_EN_OUT;
	endproperty
	a_cpu_frozen: assert property (p_cpu_frozen) else $error("cpu clock running in halt");

	property p_wdt_gate;
		q.st == HSW_HALT && $past(q.st) == HSW_HALT && $past(OPT_LSO_STOP_IN) |-> !WDT_CLK_EN_OUT;
	endproperty
	a_wdt_gate: assert property (p_wdt_gate) else $error("watchdog clock not withheld");

	property p_wake_release;
		q.st == HSW_HALT && wake_any |=> q.st == HSW_WAKE;
	endproperty
	a_wake_release: assert property (p_wake_release) else $error("unmasked request did not release");

	property p_masked_hold;
		q.st == HSW_HALT && (IRQ_REQ_IN & ~q.mask) == '0 |=> q.st == HSW_HALT;
	endproperty
	a_masked_hold: assert property (p_masked_hold) else $error("masked request released halt");

	property p_vec_wait;
		q.st == HSW_HALT && wake_any && vec_ok |-> !VECTOR_TAKE_OUT [*8] ##1 VECTOR_TAKE_OUT;
	endproperty
	a_vec_wait: assert property (p_vec_wait) else $error("vectored wake wait not 8 clocks");

	property p_next_wait;
		q.st == HSW_HALT && wake_any && !vec_ok |-> ##1 !RESUME_NEXT_OUT ##1 RESUME_NEXT_OUT && !VECTOR_TAKE_OUT;
	endproperty
	a_next_wait: assert property (p_next_wait) else $error("next-instruction wait not 2 clocks");

	property p_low_rank;
		q.st == HSW_HALT && wake_any && q.rank[wake_src] && !CURRENT_SERVICE_RANK_IN |-> ##2 RESUME_NEXT_OUT;
	endproperty
	a_low_rank: assert property (p_low_rank) else $error("low rank serviced without rank flag");

	property p_boot;
		!q.boot_done ##1 q.boot_done |-> BOOT_VECTOR_OUT && q.st == HSW_RUN && CPU_CLK_EN_OUT;
	endproperty
	a_boot: assert property (p_boot) else $error("reset vector start missing");

	property p_osc_on;
		q.st != HSW_RUN |-> MAIN_OSC_EN_OUT;
	endproperty
	a_osc_on: assert property (p_osc_on) else $error("main oscillator stopped in halt");

	// entry bookkeeping: the strobe counts only while running
	property p_no_reentry;
		q.st != HSW_RUN && HALT_EXEC_IN |=> q.halt_cnt == $past(q.halt_cnt);
	endproperty
	a_no_reentry: assert property (p_no_reentry) else $error("halt strobe taken outside run");

	property p_entry_count;
		q.st == HSW_RUN && HALT_EXEC_IN |=> q.halt_cnt == $past(q.halt_cnt) + 8'h01;
	endproperty
	a_entry_count: assert property (p_entry_count) else $error("halt entry not counted");

	property p_wake_no_entry;
		q.st == HSW_WAKE |=> q.st != HSW_HALT;
	endproperty
	a_wake_no_entry: assert property (p_wake_no_entry) else $error("halt re-entered while waking");

	// wake sequencing: wait counter, pulses and the frozen decision
	property p_cnt_bound;
		q.st == HSW_WAKE |-> q.cnt <= HSW_CNT_VEC;
	endproperty
	a_cnt_bound: assert property (p_cnt_bound) else $error("wake counter beyond longest wait");

	property p_halted_quiet;
		HALTED_OUT |-> !RESUME_NEXT_OUT && !VECTOR_TAKE_OUT;
	endproperty
	a_halted_quiet: assert property (p_halted_quiet) else $error("completion pulse while halted");

	property p_pulse_excl;
		!(RESUME_NEXT_OUT && VECTOR_TAKE_OUT);
	endproperty
	a_pulse_excl: assert property (p_pulse_excl) else $error("resume and vector pulses together");

	property p_resume_clock;
		RESUME_NEXT_OUT || VECTOR_TAKE_OUT |-> CPU_CLK_EN_OUT && !HALTED_OUT;
	endproperty
	a_resume_clock: assert property (p_resume_clock) else $error("core still gated at resume");

	property p_accept_off;
		q.st == HSW_HALT && wake_any && !GLOBAL_IRQ_ACCEPT_IN |-> ##2 RESUME_NEXT_OUT;
	endproperty
	a_accept_off: assert property (p_accept_off) else $error("request serviced with accept off");

	property p_high_rank_served;
		q.st == HSW_HALT && wake_any && !q.rank[wake_src] && GLOBAL_IRQ_ACCEPT_IN |-> ##8 VECTOR_TAKE_OUT;
	endproperty
	a_high_rank_served: assert property (p_high_rank_served) else $error("high rank not vectored");

	property p_low_rank_served;
		q.st == HSW_HALT && wake_any && q.rank[wake_src] && GLOBAL_IRQ_ACCEPT_IN && CURRENT_SERVICE_RANK_IN
			|-> ##8 VECTOR_TAKE_OUT;
	endproperty
	a_low_rank_served: assert property (p_low_rank_served) else $error("low rank not vectored");

	property p_vec_src;
		q.st == HSW_HALT && wake_any |=> q.src == $past(wake_src);
	endproperty
	a_vec_src: assert property (p_vec_src) else $error("released source not recorded");

	property p_wake_frozen;
		q.st == HSW_WAKE |=> q.src == $past(q.src) && q.vec_pend == $past(q.vec_pend);
	endproperty
	a_wake_frozen: assert property (p_wake_frozen) else $error("wake decision changed while waiting");

	// clock enables around halt
	property p_wdt_run;
		q.st == HSW_RUN |-> WDT_CLK_EN_OUT;
	endproperty
	a_wdt_run: assert property (p_wdt_run) else $error("watchdog clock off while running");

	property p_wdt_free;
		q.st != HSW_RUN && !$past(OPT_LSO_STOP_IN) |-> WDT_CLK_EN_OUT;
	endproperty
	a_wdt_free: assert property (p_wdt_free) else $error("watchdog clock withheld without option");

	property p_boot_run;
		BOOT_VECTOR_OUT |-> !HALTED_OUT && CPU_CLK_EN_OUT;
	endproperty
	a_boot_run: assert property (p_boot_run) else $error("reset vector start while halted");

	// register bus: one wait cycle, single-cycle answer, mask lands on completion
	property p_mask_write;
		acc && AVS_REQ_IN.write && AVS_REQ_IN.address == HSW_OFS_MASK && AVS_REQ_IN.byteenable[0]
			|=> q.mask == $past(AVS_REQ_IN.writedata[NSRC-1:0]);
	endproperty
	a_mask_write: assert property (p_mask_write) else $error("mask write did not land");

	property p_bus_answer;
		(AVS_REQ_IN.read || AVS_REQ_IN.write) && AVS_RSP_OUT.waitrequest |=> !AVS_RSP_OUT.waitrequest;
	endproperty
	a_bus_answer: assert property (p_bus_answer) else $error("bus request not answered after one wait");

	property p_bus_single;
		!AVS_RSP_OUT.waitrequest |=> AVS_RSP_OUT.waitrequest;
	endproperty
	a_bus_single: assert property (p_bus_single) else $error("bus answer held longer than one cycle");

	// ---------------------------------------------------------------
	// coverage
	// ---------------------------------------------------------------
	// main scenarios: both wake kinds, a halt held for eight cycles, a low-rank vector, a bus write
	c_vec_wake:  cover property (q.st == HSW_HALT && wake_any && vec_ok ##8 VECTOR_TAKE_OUT);
	c_next_wake: cover property (q.st == HSW_HALT && wake_any && !vec_ok ##2 RESUME_NEXT_OUT);
	c_long_halt: cover property (q.st == HSW_HALT [*8]);
	c_bus_write: cover property (acc && AVS_REQ_IN.write);
	c_low_vec:   cover property (q.st == HSW_HALT && wake_any && q.rank[wake_src] && vec_ok);

endmodule // hsw_halt_wake

`default_nettype wire

// file: verilog/hsw_pkg.sv
// Purpose: shared constants and types of the halt standby wake control block
// Assumes: one 200 MHz clock; cpu clock equals the system clock for wait counts
// Notes:   register offsets are byte addresses on a 32-bit avalon-mm slave
package hsw_pkg;

	// ---------------------------------------------------------------
	// sizes
	// ---------------------------------------------------------------
	localparam int NSRC = 8;
	localparam int SRCW = 3;

	// ---------------------------------------------------------------
	// register map
	// ---------------------------------------------------------------
	localparam logic [3:0] HSW_OFS_MASK   = 4'h0;
	localparam logic [3:0] HSW_OFS_RANK   = 4'h4;
	localparam logic [3:0] HSW_OFS_STATUS = 4'h8;
	localparam logic [3:0] HSW_OFS_COUNT  = 4'hc;
	localparam logic [7:0] HSW_MASK_RST   = 8'hff;
	localparam logic [7:0] HSW_RANK_RST   = 8'hff;
	// status field positions
	localparam int HSW_ST_HALTED = 0;
	localparam int HSW_ST_WAKING = 1;
	localparam int HSW_ST_LASTV  = 2;
	localparam int HSW_ST_CLKSRC = 3;
	localparam int HSW_ST_SRC_LO = 4;

	// ---------------------------------------------------------------
	// wake-up waits in cpu clocks
	// ---------------------------------------------------------------
	localparam int         HSW_WAIT_VEC_CLK  = 8;
	localparam int         HSW_WAIT_NEXT_CLK = 2;
	localparam logic [3:0] HSW_CNT_VEC       = 4'(HSW_WAIT_VEC_CLK - 2);
	localparam logic [3:0] HSW_CNT_NEXT      = 4'(HSW_WAIT_NEXT_CLK - 2);

	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		HSW_RUN  = 2'b00,
		HSW_HALT = 2'b01,
		HSW_WAKE = 2'b10
	} hsw_state_t;

	typedef struct packed {
		logic        read;
		logic        write;
		logic [3:0]  address;
		logic [3:0]  byteenable;
		logic [31:0] writedata;
	} hsw_avs_req_t;

	typedef struct packed {
		logic        waitrequest;
		logic [31:0] readdata;
	} hsw_avs_rsp_t;

	typedef struct packed {
		hsw_state_t   st;
		logic [3:0]   cnt;
		logic         vec_pend;
		logic [SRCW-1:0] src;
		logic [NSRC-1:0] mask;
		logic [NSRC-1:0] rank;
		logic         clk_src;
		logic         last_vec;
		logic [7:0]   halt_cnt;
		logic         cpu_en;
		logic         wdt_en;
		logic         osc_en;
		logic         resume_p;
		logic         vector_p;
		logic [SRCW-1:0] vec_src;
		logic         boot_p;
		logic         boot_done;
		logic         halted;
		hsw_avs_rsp_t rsp;
	} hsw_reg_t;

	localparam hsw_reg_t HSW_REG_RST = '{
		st: HSW_RUN, cnt: 4'h0, vec_pend: 1'b0, src: 3'h0,
		mask: HSW_MASK_RST, rank: HSW_RANK_RST, clk_src: 1'b0, last_vec: 1'b0,
		halt_cnt: 8'h00, cpu_en: 1'b1, wdt_en: 1'b1, osc_en: 1'b1,
		resume_p: 1'b0, vector_p: 1'b0, vec_src: 3'h0, boot_p: 1'b0,
		boot_done: 1'b0, halted: 1'b0, rsp: '{waitrequest: 1'b1, readdata: 32'h0000_0000}
	};

endpackage
